/* hbg_bridge_ctrl.sv */
// Purpose: gate control and protection of a two-leg bridge driver
// Assumes: analog comparators deliver digital flags; reset = power cycle
// Notes:   all pin inputs pass a two-flop synchroniser first
`timescale 1ns/100ps
`include "hbg_map.svh"
module hbg_bridge_ctrl #(
   parameter int OFF_CYCLES   = `HBG_OFF_CYCLES,
   parameter int BLANK_CYCLES = `HBG_BLANK_CYCLES
) (
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   // control pins from the controller
   input  wire logic polarity_in_a_i,
   input  wire logic polarity_in_b_i,
   input  wire logic disable_a_i,
   input  wire logic enable_disable_b_i,
   // comparator flags from the analog side
   input  wire logic undervoltage_i,
   input  wire logic short_circuit_i,
   input  wire logic over_current_i,
   input  wire logic over_current_fold_i,
   input  wire logic temp_fold_i,
   input  wire logic temp_trip_i,
   input  wire logic temp_clear_hyst_i,
   // bridge legs, output enable low while driving
   output logic      bridge_out_a_o,
   output logic      bridge_out_a_oe_n_o,
   output logic      bridge_out_b_o,
   output logic      bridge_out_b_oe_n_o,
   // open-drain fault flag, enable low pulls the pin low
   output logic      fault_flag_n_o,
   output logic      fault_flag_oe_n_o,
   // status
   output logic      sleep_o,
   output logic      fold_active_o
);
   localparam int TW = `HBG_TIMER_W;
   hbg_pkg::hbg_ctrl_t  ctrl;
   hbg_pkg::hbg_sense_t sense;
   hbg_pkg::hbg_state_t state;
   hbg_pkg::hbg_state_t next_state;
   hbg_pkg::hbg_leg_t   next_leg_a;
   hbg_pkg::hbg_leg_t   next_leg_b;
   logic       oc_fold;
   logic       oc_hit;
   logic       dis_a_q;
   logic       en_q;
   logic       clear_en;
   logic       clear_dis;
   logic       ot_latched;
   logic       latch_req;
   logic       off_busy;
   logic       blank_busy;
   logic       drive_q_a;
   logic       drive_q_b;
   logic       drive_now;
   logic       transition;
   logic       next_flag_n;
   initial begin
      if (OFF_CYCLES < 1 || OFF_CYCLES >= (1 << TW))
         $error("hbg_bridge_ctrl: OFF_CYCLES out of range");
      if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << TW))
         $error("hbg_bridge_ctrl: BLANK_CYCLES out of range");
   end
   // control pins; enable resets low so a floating pin means sleep
   hbg_sync #(.WIDTH(4), .RESET_VAL(4'h2)) u_sync_ctrl (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   ({polarity_in_a_i, polarity_in_b_i, disable_a_i,
                   enable_disable_b_i}),
      .sync_o    (ctrl)
   );
   // analog flags
   hbg_sync #(.WIDTH(6), .RESET_VAL(6'h00)) u_sync_sense (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   ({undervoltage_i, short_circuit_i, over_current_i,
                   temp_fold_i, temp_trip_i, temp_clear_hyst_i}),
      .sync_o    (sense)
   );
   // folded current comparator
   hbg_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_sync_oc (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (over_current_fold_i),
      .sync_o    (oc_fold)
   );
   // threshold picks the folded comparator when hot
   assign oc_hit = sense.temp_fold ? oc_fold : sense.over_current;
   // edge history of the clearing inputs
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         dis_a_q <= 1'b1; // pin idles high, no false fall
         en_q    <= 1'b0;
      end else begin
         dis_a_q <= ctrl.disable_a;
         en_q    <= ctrl.enable_disable_b;
      end
   end
   // enable rise clears below trip; disable_a fall needs hysteresis
   assign clear_en  = ctrl.enable_disable_b & ~en_q &
                      (~ot_latched | ~sense.temp_trip);
   assign clear_dis = ~ctrl.disable_a & dis_a_q &
                      (~ot_latched | sense.temp_clear_hyst);
   // fault detection; blanking lets the short comparator act
   assign latch_req = sense.short_circuit | sense.temp_trip;
   // which cause latched, for the clear thresholds
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ot_latched <= 1'b0;
      end else if (state != hbg_pkg::HBG_LATCHED) begin
         ot_latched <= sense.temp_trip;
      end
   end
   // main state sequencing
   always_comb begin
      next_state = state;
      case (state)
         hbg_pkg::HBG_SLEEP: begin
            if (ctrl.enable_disable_b && latch_req)
               next_state = hbg_pkg::HBG_LATCHED;
            else if (ctrl.enable_disable_b)
               next_state = hbg_pkg::HBG_RUN;
         end
         hbg_pkg::HBG_RUN, hbg_pkg::HBG_CHOP: begin
            if (!ctrl.enable_disable_b)
               next_state = hbg_pkg::HBG_SLEEP;
            else if (latch_req)
               next_state = hbg_pkg::HBG_LATCHED;
            else if (sense.undervoltage)
               next_state = hbg_pkg::HBG_UVLO;
            else if (state == hbg_pkg::HBG_RUN && drive_now &&
                     oc_hit && !blank_busy)
               next_state = hbg_pkg::HBG_CHOP;
            else if (state == hbg_pkg::HBG_CHOP && !off_busy)
               next_state = hbg_pkg::HBG_RUN;
         end
         hbg_pkg::HBG_UVLO: begin
            if (!ctrl.enable_disable_b)
               next_state = hbg_pkg::HBG_SLEEP;
            else if (!sense.undervoltage)
               next_state = hbg_pkg::HBG_RUN;
         end
         hbg_pkg::HBG_LATCHED: begin
            if (clear_en || clear_dis)
               next_state = hbg_pkg::HBG_RUN;
            else if (!ctrl.enable_disable_b)
               next_state = hbg_pkg::HBG_SLEEP;
         end
         default: next_state = hbg_pkg::HBG_SLEEP;
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state <= hbg_pkg::HBG_SLEEP;
      end else begin
         state <= next_state;
      end
   end
   // outputs drive only in run state, disable_a low, no fault pending
   assign drive_now = (state == hbg_pkg::HBG_RUN) & ~ctrl.disable_a &
                      ~latch_req & ~sense.undervoltage;
   // track commanded levels so each output transition is seen
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         drive_q_a <= 1'b0;
         drive_q_b <= 1'b0;
      end else begin
         drive_q_a <= ctrl.polarity_in_a;
         drive_q_b <= ctrl.polarity_in_b;
      end
   end
   assign transition = (drive_q_a != ctrl.polarity_in_a) |
                       (drive_q_b != ctrl.polarity_in_b) |
                       (drive_now & ~(next_leg_a.oe_n == 1'b0 &
                        bridge_out_a_oe_n_o == 1'b0));
   // off time after a current limit trip
   hbg_timer #(.WIDTH(TW)) u_off_timer (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .start_i   (state == hbg_pkg::HBG_RUN &&
                  next_state == hbg_pkg::HBG_CHOP),
      .load_i    (TW'(OFF_CYCLES)),
      .busy_o    (off_busy)
   );
   // blanking after every output transition
   hbg_timer #(.WIDTH(TW)) u_blank_timer (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .start_i   (transition),
      .load_i    (TW'(BLANK_CYCLES)),
      .busy_o    (blank_busy)
   );
   // next leg and flag values
   always_comb begin
      next_leg_a.level = ctrl.polarity_in_a;
      next_leg_b.level = ctrl.polarity_in_b;
      next_leg_a.oe_n  = ~drive_now;
      next_leg_b.oe_n  = ~drive_now;
      case (state)
         hbg_pkg::HBG_SLEEP:   next_flag_n = 1'b1;
         hbg_pkg::HBG_LATCHED: next_flag_n = 1'b0;
         hbg_pkg::HBG_UVLO:    next_flag_n = 1'b0;
         default:              next_flag_n = ~ctrl.disable_a;
      endcase
   end
   // registered outputs
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         bridge_out_a_o      <= 1'b0;
         bridge_out_a_oe_n_o <= 1'b1;
         bridge_out_b_o      <= 1'b0;
         bridge_out_b_oe_n_o <= 1'b1;
         fault_flag_n_o      <= 1'b1;
         fault_flag_oe_n_o   <= 1'b1;
         sleep_o             <= 1'b1;
         fold_active_o       <= 1'b0;
      end else begin
         bridge_out_a_o      <= next_leg_a.level;
         bridge_out_a_oe_n_o <= next_leg_a.oe_n;
         bridge_out_b_o      <= next_leg_b.level;
         bridge_out_b_oe_n_o <= next_leg_b.oe_n;
         fault_flag_n_o      <= next_flag_n;
         fault_flag_oe_n_o   <= next_flag_n; // drives low only
         sleep_o             <= (state == hbg_pkg::HBG_SLEEP);
         fold_active_o       <= sense.temp_fold;
      end
   end

   // named sequences for the chop cycle
   sequence s_chop_start;
      state == hbg_pkg::HBG_RUN && next_state == hbg_pkg::HBG_CHOP;
   endsequence
   sequence s_off_hold;
      bridge_out_a_oe_n_o [*8];
   endsequence

   a_sleep_tristate: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_SLEEP |=> bridge_out_a_oe_n_o &&
         bridge_out_b_oe_n_o && fault_flag_n_o)
      else $error("sleep does not tri-state with flag high");
   a_disable_flag: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      ctrl.disable_a && state == hbg_pkg::HBG_RUN |=>
         !fault_flag_n_o && bridge_out_b_oe_n_o)
      else $error("disable does not tri-state and flag low");
   a_drive_follow: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      drive_now |=> !bridge_out_a_oe_n_o &&
         bridge_out_a_o == $past(ctrl.polarity_in_a) &&
         bridge_out_b_o == $past(ctrl.polarity_in_b))
      else $error("outputs do not follow polarity inputs");
   a_latch_hold: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_LATCHED && !clear_en && !clear_dis &&
         ctrl.enable_disable_b |=> state == hbg_pkg::HBG_LATCHED)
      else $error("latched fault left without a clear");
   a_latch_time: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      $rose(sense.short_circuit) && state == hbg_pkg::HBG_RUN
         |-> ##[1:2] bridge_out_a_oe_n_o && !fault_flag_n_o)
      else $error("latch-off too slow");
   a_uv_recover: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_UVLO && !sense.undervoltage &&
         ctrl.enable_disable_b |=> state == hbg_pkg::HBG_RUN)
      else $error("undervoltage recovery not automatic");
   a_off_time: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      s_chop_start ##1 (state == hbg_pkg::HBG_CHOP) |=> s_off_hold)
      else $error("off time ended early");
   a_blank_mask: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      blank_busy && state == hbg_pkg::HBG_RUN |=>
         state != hbg_pkg::HBG_CHOP)
      else $error("current limit acted during blanking");
   a_ot_clear: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_LATCHED && ot_latched &&
         !sense.temp_clear_hyst && !clear_en |=>
         state != hbg_pkg::HBG_RUN)
      else $error("overtemp cleared above hysteresis");
   // outcomes of the protection states
   a_uv_tristate: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_UVLO |=> bridge_out_a_oe_n_o &&
         bridge_out_b_oe_n_o && !fault_flag_n_o)
      else $error("undervoltage does not tri-state with flag low");
   a_latch_tristate: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_LATCHED |=> bridge_out_a_oe_n_o &&
         bridge_out_b_oe_n_o && !fault_flag_n_o)
      else $error("latched fault does not tri-state with flag low");
   a_chop_tristate: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_CHOP |=> bridge_out_a_oe_n_o &&
         bridge_out_b_oe_n_o)
      else $error("outputs driven during off time");
   a_hot_relatch: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      state == hbg_pkg::HBG_SLEEP && ctrl.enable_disable_b &&
         sense.temp_trip |=> state == hbg_pkg::HBG_LATCHED)
      else $error("enable cleared an overtemperature latch while hot");
endmodule

/* hbg_map.svh */
// Purpose: constants for the bridge gate control and fault logic
// Assumes: 200 MHz system clock, period 5 ns
// Notes:   times held in ns, cycle counts derived below
// Operation
// - enabled: outputs follow polarity inputs, freewheel both
// - disable_a high: outputs high-z, flag low
// - enable low: tri-state at once, sleep, flag high
// - fully operational only while enable high
// - floating enable defaults to sleep mode
// - flag low on disable, undervoltage, faults
// - undervoltage tri-states, recovers automatically without toggle
// - short or overtemp latches outputs off, flag
// - disable_a fall or enable rise clears latch
// - overtemp clear thresholds differ per input
// - current limit tri-states for fixed off time
// - blanking restarts each transition, masks current limit
// - hot lowers limit, hotter trips overtemp latch
// - power cycle clears latched fault
// - blanking interval 16.5 us typical
// - latch-off within 8.0 us of detection
`ifndef HBG_MAP_SVH
`define HBG_MAP_SVH
`define HBG_CLK_PERIOD_NS  5
`define HBG_OFF_TIME_NS    20000
`define HBG_BLANK_TIME_NS  16500
`define HBG_LATCH_MAX_NS   8000
`define HBG_OFF_CYCLES     (`HBG_OFF_TIME_NS / `HBG_CLK_PERIOD_NS)
`define HBG_BLANK_CYCLES   (`HBG_BLANK_TIME_NS / `HBG_CLK_PERIOD_NS)
`define HBG_LATCH_CYCLES   (`HBG_LATCH_MAX_NS / `HBG_CLK_PERIOD_NS)
`define HBG_TIMER_W        13
`endif

/* hbg_mcu_model.sv */
// Purpose: controller model that drives the bridge control pins
// Assumes: pins change one cycle after the bench gives a command
// Notes:   an unpowered controller leaves its pins to the pulls
`timescale 1ns/100ps
module hbg_mcu_model (
   // clock
   input  wire logic               clk_sys_i,
   // command from the bench, off = controller unpowered
   input  wire hbg_pkg::hbg_ctrl_t cmd_i,
   input  wire logic               off_i,
   // pins towards the bridge
   output hbg_pkg::hbg_ctrl_t      pin_o,
   // open-drain flag and its pulled-up pin
   input  wire logic               flag_oe_n_i,
   output logic                    flag_pin_o
);
   // pins follow the command, so the clearing toggles come from it too
   always_ff @(posedge clk_sys_i) begin
      if (off_i) begin
         pin_o <= 4'hE; // the enable pull-down wins when unpowered
      end else begin
         pin_o <= cmd_i; // disable fall or enable rise clears a latch
      end
   end
   // pull-up holds the flag high unless the device pulls it down
   assign flag_pin_o = flag_oe_n_i ? 1'h1 : 1'h0;
endmodule

/* hbg_pkg.sv */
// Purpose: types for the bridge gate control and fault logic
// Assumes: nothing beyond the header constants
// Notes:   states and pin bundles
package hbg_pkg;
   typedef enum logic [2:0] {
      HBG_SLEEP   = 3'b000,
      HBG_RUN     = 3'b001,
      HBG_CHOP    = 3'b010,
      HBG_LATCHED = 3'b011,
      HBG_UVLO    = 3'b100
   } hbg_state_t;
   // synchronised control inputs
   typedef struct packed {
      logic polarity_in_a;
      logic polarity_in_b;
      logic disable_a;
      logic enable_disable_b;
   } hbg_ctrl_t;
   // synchronised analog comparator flags
   typedef struct packed {
      logic undervoltage;
      logic short_circuit;
      logic over_current;
      logic temp_fold;
      logic temp_trip;
      logic temp_clear_hyst;
   } hbg_sense_t;
   // one half-bridge: level and output enable (low = driving)
   typedef struct packed {
      logic level;
      logic oe_n;
   } hbg_leg_t;
endpackage

/* hbg_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: inputs asynchronous to clk_sys_i
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
module hbg_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   // data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   initial begin
      if (WIDTH < 1) $error("hbg_sync: WIDTH must be at least 1");
   end
   // two flip-flop stages per bit
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         stage1 <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

/* hbg_timer.sv */
// Purpose: down-counting interval timer with restart
// Assumes: load value fits WIDTH bits
// Notes:   busy stays high for exactly load cycles after start
`timescale 1ns/100ps
module hbg_timer #(
   parameter int WIDTH = 13
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   // control
   input  wire logic             start_i,
   input  wire logic [WIDTH-1:0] load_i,
   output logic                  busy_o
);
   logic [WIDTH-1:0] count;
   initial begin
      if (WIDTH < 2) $error("hbg_timer: WIDTH must be at least 2");
   end
   // restart on start, else count down to zero
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         count <= '0;
      end else if (start_i) begin
         count <= load_i;
      end else if (count != '0) begin
         count <= count - WIDTH'(1);
      end
   end
   assign busy_o = (count != '0);
endmodule

/* tb.sv */
// Purpose: self-checking bench for the bridge gate control logic
// Assumes: off time 20 and blanking 10 cycles to keep the run short
// Notes:   the expected outputs come from a latch model kept in lat
`timescale 1ns/100ps
module tb;
   logic               clk_sys_i, reset_i, off, uv, sc, oc, ocf;
   logic               tfold, ttrip, thyst, oa, oa_n, ob, ob_n;
   logic               flag_oe_n, flag_pin, sleep, fold, flag;
   hbg_pkg::hbg_ctrl_t cmd, pin;
   int                 fail_count, check_count, lat;
   logic [31:0]        lfsr;

   hbg_mcu_model mcu (.clk_sys_i(clk_sys_i), .cmd_i(cmd), .off_i(off),
      .pin_o(pin), .flag_oe_n_i(flag_oe_n), .flag_pin_o(flag_pin));
   // off time and blanking as short cycle counts
   hbg_bridge_ctrl #(.OFF_CYCLES(20), .BLANK_CYCLES(10)) dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .polarity_in_a_i(pin.polarity_in_a),
      .polarity_in_b_i(pin.polarity_in_b),
      .disable_a_i(pin.disable_a),
      .enable_disable_b_i(pin.enable_disable_b),
      .undervoltage_i(uv), .short_circuit_i(sc), .over_current_i(oc),
      .over_current_fold_i(ocf), .temp_fold_i(tfold),
      .temp_trip_i(ttrip), .temp_clear_hyst_i(thyst),
      .bridge_out_a_o(oa), .bridge_out_a_oe_n_o(oa_n),
      .bridge_out_b_o(ob), .bridge_out_b_oe_n_o(ob_n),
      .fault_flag_n_o(flag), .fault_flag_oe_n_o(flag_oe_n),
      .sleep_o(sleep), .fold_active_o(fold));

   // free-running 200 MHz clock
   initial begin
      clk_sys_i = 1'h0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input string name, input logic seen, input logic exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic conclude();
      if (fail_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // compare every output except fold_active_o with what the model predicts
   task automatic compare_all();
      logic en, z, fl;
      en = cmd.enable_disable_b & !off;
      z  = !en | (lat != 0) | uv | cmd.disable_a;
      fl = !en | !z;
      check("oe_a", oa_n, z);
      check("oe_b", ob_n, z);
      check("flag", flag_pin, fl);
      check("flag_oe", flag_oe_n, fl);
      check("flag_n", flag, fl);
      check("sleep", sleep, !en);
      if (!z) begin
         check("lvl_a", oa, cmd.polarity_in_a);
         check("lvl_b", ob, cmd.polarity_in_b);
      end
   endtask

   // new command; the model clears its latch on the documented toggles
   task automatic step(input hbg_pkg::hbg_ctrl_t c);
      @(posedge clk_sys_i);
      if (lat != 0 && c.enable_disable_b && !cmd.enable_disable_b
          && (lat == 1 || !ttrip)) lat = 0;
      if (lat != 0 && cmd.disable_a && !c.disable_a && c.enable_disable_b
          && (lat == 1 || thyst)) lat = 0;
      cmd <= c;
      tick(8);
      compare_all();
   endtask

   // kind 1 is a short pulse, kind 2 an overtemperature that stays high
   task automatic fault(input int kind);
      @(posedge clk_sys_i);
      if (kind == 1) sc <= 1'h1;
      else ttrip <= 1'h1;
      lat = kind;
      tick(6);
      compare_all();
      @(posedge clk_sys_i);
      sc <= 1'h0;
   endtask

   // one-cycle comparator pulse, then off time and resumed drive
   task automatic chop(input logic fold_path, input logic exp);
      @(posedge clk_sys_i);
      if (fold_path) ocf <= 1'h1;
      else oc <= 1'h1;
      @(posedge clk_sys_i);
      oc  <= 1'h0;
      ocf <= 1'h0;
      tick(5);
      check("chop_a", oa_n, exp);
      check("chop_flag", flag, 1'h1);
      tick(12);
      check("chop_b", ob_n, exp);
      tick(14);
      check("resume", oa_n, 1'h0);
   endtask

   // watchdog far beyond the expected run of under 2000 cycles
   initial begin
      #50000;
      fail_count++;
      conclude();
   end

   initial begin
      reset_i = 1'h1;
      off = 1'h0;
      {uv, sc, oc, ocf, tfold, ttrip, thyst} = 7'h00;
      cmd = 4'h0;
      fail_count = 0;
      check_count = 0;
      lat = 0;
      lfsr = 32'hB167;
      tick(11);
      compare_all();
      @(posedge clk_sys_i);
      reset_i <= 1'h0;
      // every input code, then random ones
      for (int i = 0; i < 16; i++) step(i[3:0]);
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         step(hbg_pkg::hbg_ctrl_t'(lfsr[3:0]));
      end
      // unpowered controller, then undervoltage with auto recovery
      step(4'h9);
      @(posedge clk_sys_i);
      off <= 1'h1;
      tick(8);
      compare_all();
      @(posedge clk_sys_i);
      off <= 1'h0;
      tick(8);
      @(posedge clk_sys_i);
      uv <= 1'h1;
      tick(8);
      compare_all();
      @(posedge clk_sys_i);
      uv <= 1'h0;
      tick(8);
      compare_all();
      // short: inputs ignored, cleared by disable fall and by enable rise
      fault(1);
      step(4'h5);
      step(4'h7);
      step(4'h5);
      fault(1);
      step(4'h4);
      step(4'h5);
      // a power cycle clears a latched short
      fault(1);
      @(posedge clk_sys_i);
      reset_i <= 1'h1;
      lat = 0;
      tick(3);
      @(posedge clk_sys_i);
      reset_i <= 1'h0;
      tick(8);
      compare_all();
      // overtemperature: each clear input has its own threshold
      fault(2);
      step(4'h4);
      step(4'h5);
      @(posedge clk_sys_i);
      ttrip <= 1'h0;
      step(4'h7);
      step(4'h5);
      step(4'h4);
      step(4'h5);
      fault(2);
      @(posedge clk_sys_i);
      ttrip <= 1'h0;
      thyst <= 1'h1;
      step(4'h7);
      step(4'h5);
      @(posedge clk_sys_i);
      thyst <= 1'h0;
      // chopping after blanking, masked inside blanking, fold threshold
      step(4'h9);
      tick(20);
      chop(1'h0, 1'h1);
      @(posedge clk_sys_i);
      cmd <= 4'h5;
      tick(2);
      chop(1'h0, 1'h0);
      tick(20);
      chop(1'h1, 1'h0);
      @(posedge clk_sys_i);
      tfold <= 1'h1;
      tick(20);
      check("fold", fold, 1'h1);
      chop(1'h1, 1'h1);
      conclude();
   end
endmodule
